// >>> lmr_pkg.sv
// constants, types and encodings for the literal, move and return execution unit
// assumes one 250 MHz clock domain and an apb master that issues instruction words
package lmr_pkg;

    // apb register byte offsets
    localparam logic [11:0] OFS_INSTR    = 12'h000;
    localparam logic [11:0] OFS_WORK     = 12'h004;
    localparam logic [11:0] OFS_BANK     = 12'h008;
    localparam logic [11:0] OFS_PAGE     = 12'h00c;
    localparam logic [11:0] OFS_OPTION   = 12'h010;
    localparam logic [11:0] OFS_FSP0     = 12'h014;
    localparam logic [11:0] OFS_FSP1     = 12'h018;
    localparam logic [11:0] OFS_PC       = 12'h01c;
    localparam logic [11:0] OFS_INTCTL   = 12'h020;
    localparam logic [11:0] OFS_PWRCTL   = 12'h028;
    localparam logic [11:0] OFS_FLAGS    = 12'h02c;
    localparam logic [11:0] OFS_STACK    = 12'h030;
    localparam logic [11:0] OFS_EXEC     = 12'h034;
    localparam logic [11:0] OFS_MEM_BASE = 12'h080;

    // field widths and positions
    localparam int          MEM_DEPTH      = 32;
    localparam int          STACK_DEPTH    = 16;
    localparam int          IRQ_EN_BIT     = 7;
    localparam int          RI_N_BIT       = 2;
    localparam int          FLAG_Z_BIT     = 2;
    localparam int          EXEC_BUSY_BIT  = 0;
    localparam int          EXEC_ILL_BIT   = 1;
    localparam int          EXEC_OVF_BIT   = 2;
    localparam int          EXEC_UNF_BIT   = 3;
    localparam logic [6:0]  FILE_INDWIN0   = 7'h00;
    localparam logic [6:0]  FILE_INDWIN1   = 7'h01;

    // reset values and step sizes
    localparam logic [7:0]  RST_OPTION     = 8'hff;
    localparam logic [7:0]  RST_PWRCTL     = 8'h04;
    localparam logic [14:0] PC_STEP        = 15'h0001;
    localparam logic [15:0] FSP_STEP       = 16'h0001;

    // 14-bit instruction encodings: fixed words and masked families
    localparam logic [13:0] OP_NOP         = 14'h0000;
    localparam logic [13:0] OP_RESET       = 14'h0001;
    localparam logic [13:0] OP_RETFI       = 14'h0009;
    localparam logic [13:0] OP_OPTION      = 14'h0062;
    localparam logic [13:0] MSK_BANK       = 14'h3fe0;
    localparam logic [13:0] PAT_BANK       = 14'h0020;
    localparam logic [13:0] MSK_PAGE       = 14'h3f80;
    localparam logic [13:0] PAT_PAGE       = 14'h3180;
    localparam logic [13:0] MSK_WLIT       = 14'h3f00;
    localparam logic [13:0] PAT_WLIT       = 14'h3000;
    localparam logic [13:0] MSK_WFILE      = 14'h3f80;
    localparam logic [13:0] PAT_WFILE      = 14'h0080;
    localparam logic [13:0] MSK_IND        = 14'h3ff0;
    localparam logic [13:0] PAT_IND        = 14'h0010;
    localparam logic [13:0] MSK_REL        = 14'h3f00;
    localparam logic [13:0] PAT_REL        = 14'h3f00;

    // pointer mode field codes
    localparam logic [1:0]  MODE_PREINC    = 2'b00;
    localparam logic [1:0]  MODE_PREDEC    = 2'b01;
    localparam logic [1:0]  MODE_POSTINC   = 2'b10;
    localparam logic [1:0]  MODE_POSTDEC   = 2'b11;

    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_RETFI2 = 1'b1
    } lmr_state_t;

endpackage : lmr_pkg

// >>> lmr_exec.sv
// execution unit for literal loads, moves to file/indirect, nop, software reset, return
// assumes an apb master on SYS_CLK; one instruction word is issued per write to the instr reg
//
// Behaviour
// - bank-select literal copies 5-bit operand into bank select register, flags untouched.
// - page-latch literal copies 7-bit operand into program counter high latch, no flags.
// - work literal loads 8-bit operand into working register, flags untouched.
// - work literal word must have its don't-care bits zero to decode.
// - store-work-to-file writes working register into file addressed by 7-bit operand.
// - indirect address is pointer+1 or pointer-1 (pre modes), the pointer itself (post modes) or pointer+signed offset, one of two pointers.
// - pointer mode 00 preinc, 01 predec, 10 postinc, 11 postdec.
// - pointer ends +1 for increments, -1 for decrements, unchanged for relative form.
// - store-work-to-file into indirect window goes to the location the matching pointer holds; indirect forms are not redirected.
// - pointer steps wrap modulo 16 bits.
// - pointer steps never change any status flag.
// - load-option copies working register into option register, flags untouched.
// - software reset resets the device and clears the active-low reset-instruction flag.
// - return-from-interrupt pops the stack and loads top value into program counter.
// - return-from-interrupt sets global interrupt enable, bit 7 of interrupt control.
// - return-from-interrupt is one word, two cycles, flags unchanged.
// - indirect load uses same pointer modes, moves data into work, updates zero flag.
`timescale 1ns/1ps
`default_nettype none

module lmr_exec
    import lmr_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // one-cycle pulse when the software reset instruction executes
    output logic             SOFT_RST_PULSE
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    lmr_state_t  state_r, state_nxt;
    logic [13:0] instr_r, instr_nxt;
    logic [7:0]  work_r, work_nxt;
    logic [4:0]  bank_select_reg_r, bank_select_reg_nxt;
    logic [6:0]  program_counter_high_latch_r, program_counter_high_latch_nxt;
    logic [7:0]  option_r, option_nxt;
    logic [15:0] fsp_r [2];
    logic [15:0] fsp_nxt [2];
    logic [14:0] pc_r, pc_nxt;
    logic [7:0]  interrupt_control_reg_r, interrupt_control_reg_nxt;
    logic [7:0]  power_control_reg_r, power_control_reg_nxt;
    logic [2:0]  flags_r, flags_nxt;
    logic [14:0] stack_r [STACK_DEPTH];
    logic [14:0] stack_nxt [STACK_DEPTH];
    logic [4:0]  depth_r, depth_nxt;
    logic [3:0]  exec_r, exec_nxt;
    logic [7:0]  mem_r [MEM_DEPTH];
    logic [7:0]  mem_nxt [MEM_DEPTH];
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        srst_r, srst_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // effective address for the pre/post modes of an indirect access
    function automatic logic [15:0] mode_addr(input logic [15:0] p, input logic [1:0] m);
        logic [15:0] a;
        a = p;
        unique case (m)
            MODE_PREINC:  a = p + FSP_STEP;
            MODE_PREDEC:  a = p - FSP_STEP;
            MODE_POSTINC: a = p;
            MODE_POSTDEC: a = p;
        endcase
        return a;
    endfunction : mode_addr

    // pointer value after an indirect access in pre/post modes
    function automatic logic [15:0] mode_ptr(input logic [15:0] p, input logic [1:0] m);
        logic [15:0] q;
        q = (m[0] == 1'b0) ? p + FSP_STEP : p - FSP_STEP;
        return q;
    endfunction : mode_ptr

    // storage index of a data address
    function automatic logic [4:0] mem_idx(input logic [15:0] a);
        return a[4:0];
    endfunction : mem_idx

    // zero-extend an 8-bit register value onto the 32-bit read bus
    function automatic logic [31:0] zext8(input logic [7:0] v);
        return {24'h000000, v};
    endfunction : zext8

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic: apb slave, instruction execution, second return cycle

    always_comb
    begin
        logic        take;
        logic        mapped;
        logic [31:0] rd;
        logic [13:0] op;
        logic        n;
        logic [15:0] ea;
        logic [15:0] rel;
        logic [4:0]  top;
        logic        wr_file;
        logic [15:0] wr_addr;
        logic [7:0]  rd_val;
        take    = 1'b0;
        mapped  = 1'b1;
        rd      = 32'h00000000;
        op      = PWDATA[13:0];
        n       = 1'b0;
        ea      = 16'h0000;
        rel     = 16'h0000;
        top     = 5'h00;
        wr_file = 1'b0;
        wr_addr = 16'h0000;
        rd_val  = 8'h00;

        state_nxt                       = state_r;
        instr_nxt                       = instr_r;
        work_nxt                        = work_r;
        bank_select_reg_nxt             = bank_select_reg_r;
        program_counter_high_latch_nxt  = program_counter_high_latch_r;
        option_nxt                      = option_r;
        fsp_nxt                         = fsp_r;
        pc_nxt                          = pc_r;
        interrupt_control_reg_nxt       = interrupt_control_reg_r;
        power_control_reg_nxt           = power_control_reg_r;
        flags_nxt                       = flags_r;
        stack_nxt                       = stack_r;
        depth_nxt                       = depth_r;
        exec_nxt                        = exec_r;
        mem_nxt                         = mem_r;
        prdata_nxt                      = prdata_r;
        pready_nxt                      = 1'b0;
        pslverr_nxt                     = 1'b0;
        srst_nxt                        = 1'b0;

        // address decode and read value
        // data window is exactly 0x080..0x0ff, anything above is unmapped
        if (PADDR[11:7] == OFS_MEM_BASE[11:7])
        begin
            rd = zext8(mem_r[PADDR[6:2]]);
        end
        else
        begin
            unique case (PADDR)
                OFS_INSTR:  rd = {18'h00000, instr_r};
                OFS_WORK:   rd = zext8(work_r);
                OFS_BANK:   rd = {27'h0000000, bank_select_reg_r};
                OFS_PAGE:   rd = {25'h0000000, program_counter_high_latch_r};
                OFS_OPTION: rd = zext8(option_r);
                OFS_FSP0:   rd = {16'h0000, fsp_r[0]};
                OFS_FSP1:   rd = {16'h0000, fsp_r[1]};
                OFS_PC:     rd = {17'h00000, pc_r};
                OFS_INTCTL: rd = zext8(interrupt_control_reg_r);
                OFS_PWRCTL: rd = zext8(power_control_reg_r);
                OFS_FLAGS:  rd = {29'h00000000, flags_r};
                OFS_STACK:  rd = {11'h000, depth_r, 1'b0,
                                  (depth_r == 5'h00) ? 15'h0000 : stack_r[depth_r[3:0] - 4'h1]};
                OFS_EXEC:   rd = {28'h0000000, exec_r};
                default:    mapped = 1'b0;
            endcase
        end
        if (PADDR[1:0] != 2'b00)
        begin
            mapped = 1'b0;
        end

        // access phase: answer one cycle later, stall while the return is in progress
        if (PSEL && PENABLE && !pready_r && (state_r == ST_IDLE))
        begin
            pready_nxt  = 1'b1;
            pslverr_nxt = !mapped;
            prdata_nxt  = mapped ? rd : 32'h00000000;
        end
        take = PSEL && PENABLE && pready_r && PWRITE && mapped;

        // second cycle of return-from-interrupt
        if (state_r == ST_RETFI2)
        begin
            interrupt_control_reg_nxt[IRQ_EN_BIT] = 1'b1;
            exec_nxt[EXEC_BUSY_BIT]               = 1'b0;
            state_nxt                             = ST_IDLE;
        end

        // plain register writes
        if (take && (PADDR[11:7] == OFS_MEM_BASE[11:7]))
        begin
            mem_nxt[PADDR[6:2]] = PWDATA[7:0];
        end
        else if (take)
        begin
            unique case (PADDR)
                OFS_WORK:   work_nxt = PWDATA[7:0];
                OFS_BANK:   bank_select_reg_nxt = PWDATA[4:0];
                OFS_PAGE:   program_counter_high_latch_nxt = PWDATA[6:0];
                OFS_OPTION: option_nxt = PWDATA[7:0];
                OFS_FSP0:   fsp_nxt[0] = PWDATA[15:0];
                OFS_FSP1:   fsp_nxt[1] = PWDATA[15:0];
                OFS_PC:     pc_nxt = PWDATA[14:0];
                OFS_INTCTL: interrupt_control_reg_nxt = PWDATA[7:0];
                OFS_PWRCTL: power_control_reg_nxt = PWDATA[7:0];
                OFS_FLAGS:  flags_nxt = PWDATA[2:0];
                OFS_EXEC:   exec_nxt = exec_r & ~PWDATA[3:0];
                OFS_STACK:
                begin
                    // software push of a return address
                    if (depth_r == 5'(STACK_DEPTH))
                    begin
                        exec_nxt[EXEC_OVF_BIT] = 1'b1;
                    end
                    else
                    begin
                        stack_nxt[depth_r[3:0]] = PWDATA[14:0];
                        depth_nxt               = depth_r + 5'h01;
                    end
                end
                OFS_INSTR:
                begin
                    // instruction issue: every instruction except reset and return advances the counter
                    instr_nxt = op;
                    pc_nxt    = pc_r + PC_STEP;
                    n         = op[6];
                    if (op == OP_NOP)
                    begin
                        pc_nxt = pc_r + PC_STEP;
                    end
                    else if (op == OP_RESET)
                    begin
                        state_nxt                       = ST_IDLE;
                        work_nxt                        = 8'h00;
                        bank_select_reg_nxt             = 5'h00;
                        program_counter_high_latch_nxt  = 7'h00;
                        option_nxt                      = RST_OPTION;
                        fsp_nxt[0]                      = 16'h0000;
                        fsp_nxt[1]                      = 16'h0000;
                        pc_nxt                          = 15'h0000;
                        interrupt_control_reg_nxt       = 8'h00;
                        flags_nxt                       = 3'h0;
                        depth_nxt                       = 5'h00;
                        exec_nxt                        = 4'h0;
                        power_control_reg_nxt[RI_N_BIT] = 1'b0;
                        srst_nxt                        = 1'b1;
                    end
                    else if (op == OP_RETFI)
                    begin
                        if (depth_r == 5'h00)
                        begin
                            exec_nxt[EXEC_UNF_BIT] = 1'b1;
                            pc_nxt                 = 15'h0000;
                        end
                        else
                        begin
                            top       = depth_r - 5'h01;
                            pc_nxt    = stack_r[top[3:0]];
                            depth_nxt = top;
                        end
                        exec_nxt[EXEC_BUSY_BIT] = 1'b1;
                        state_nxt               = ST_RETFI2;
                    end
                    else if (op == OP_OPTION)
                    begin
                        option_nxt = work_r;
                    end
                    else if ((op & MSK_BANK) == PAT_BANK)
                    begin
                        bank_select_reg_nxt = op[4:0];
                    end
                    else if ((op & MSK_PAGE) == PAT_PAGE)
                    begin
                        program_counter_high_latch_nxt = op[6:0];
                    end
                    else if ((op & MSK_WLIT) == PAT_WLIT)
                    begin
                        work_nxt = op[7:0];
                    end
                    else if ((op & MSK_WFILE) == PAT_WFILE)
                    begin
                        wr_file = 1'b1;
                        if (op[6:0] == FILE_INDWIN0)
                        begin
                            wr_addr = fsp_r[0];
                        end
                        else if (op[6:0] == FILE_INDWIN1)
                        begin
                            wr_addr = fsp_r[1];
                        end
                        else
                        begin
                            wr_addr = {9'h000, op[6:0]};
                        end
                    end
                    else if ((op & MSK_IND) == PAT_IND)
                    begin
                        n = op[2];
                        ea = mode_addr(fsp_r[n], op[1:0]);
                        fsp_nxt[n] = mode_ptr(fsp_r[n], op[1:0]);
                        if (op[3])
                        begin
                            wr_file = 1'b1;
                            wr_addr = ea;
                        end
                        else
                        begin
                            rd_val                = mem_r[mem_idx(ea)];
                            work_nxt              = rd_val;
                            flags_nxt[FLAG_Z_BIT] = (rd_val == 8'h00);
                        end
                    end
                    else if ((op & MSK_REL) == PAT_REL)
                    begin
                        rel = {{10{op[5]}}, op[5:0]};
                        ea  = fsp_r[n] + rel;
                        if (op[7])
                        begin
                            wr_file = 1'b1;
                            wr_addr = ea;
                        end
                        else
                        begin
                            rd_val                = mem_r[mem_idx(ea)];
                            work_nxt              = rd_val;
                            flags_nxt[FLAG_Z_BIT] = (rd_val == 8'h00);
                        end
                    end
                    else
                    begin
                        // nonzero don't-care bits or unknown word
                        exec_nxt[EXEC_ILL_BIT] = 1'b1;
                    end
                    if (wr_file)
                    begin
                        mem_nxt[mem_idx(wr_addr)] = work_r;
                    end
                end
                default:
                begin
                    pc_nxt = pc_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            state_r                      <= ST_IDLE;
            instr_r                      <= 14'h0000;
            work_r                       <= 8'h00;
            bank_select_reg_r            <= 5'h00;
            program_counter_high_latch_r <= 7'h00;
            option_r                     <= RST_OPTION;
            fsp_r[0]                     <= 16'h0000;
            fsp_r[1]                     <= 16'h0000;
            pc_r                         <= 15'h0000;
            interrupt_control_reg_r      <= 8'h00;
            power_control_reg_r          <= RST_PWRCTL;
            flags_r                      <= 3'h0;
            depth_r                      <= 5'h00;
            exec_r                       <= 4'h0;
            prdata_r                     <= 32'h00000000;
            pready_r                     <= 1'b0;
            pslverr_r                    <= 1'b0;
            srst_r                       <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++)
            begin
                stack_r[i] <= 15'h0000;
            end
            for (int i = 0; i < MEM_DEPTH; i++)
            begin
                mem_r[i] <= 8'h00;
            end
        end
        else
        begin
            state_r                      <= state_nxt;
            instr_r                      <= instr_nxt;
            work_r                       <= work_nxt;
            bank_select_reg_r            <= bank_select_reg_nxt;
            program_counter_high_latch_r <= program_counter_high_latch_nxt;
            option_r                     <= option_nxt;
            fsp_r                        <= fsp_nxt;
            pc_r                         <= pc_nxt;
            interrupt_control_reg_r      <= interrupt_control_reg_nxt;
            power_control_reg_r          <= power_control_reg_nxt;
            flags_r                      <= flags_nxt;
            stack_r                      <= stack_nxt;
            depth_r                      <= depth_nxt;
            exec_r                       <= exec_nxt;
            mem_r                        <= mem_nxt;
            prdata_r                     <= prdata_nxt;
            pready_r                     <= pready_nxt;
            pslverr_r                    <= pslverr_nxt;
            srst_r                       <= srst_nxt;
        end
    end

    // outputs straight from flops
    assign PRDATA         = prdata_r;
    assign PREADY         = pready_r;
    assign PSLVERR        = pslverr_r;
    assign SOFT_RST_PULSE = srst_r;

endmodule : lmr_exec

`default_nettype wire

// >>> lmr_exec_monitor.sv
// port assertions for the execution unit
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module lmr_exec_monitor
    import lmr_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SOFT_RST_PULSE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // completed write of the software reset word
    logic rst_wr;
    assign rst_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_INSTR
                    && PWDATA[13:0] == OP_RESET;
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_ready_once: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    a_ready_bound: assert property ($rose(PENABLE) |-> ##[1:3] PREADY)
        else $error("ready late");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_unaligned_err: assert property (PREADY && PADDR[1:0] != 2'b00 |-> PSLVERR)
        else $error("unaligned accepted");
    a_srst_follows: assert property (rst_wr |=> SOFT_RST_PULSE)
        else $error("no reset pulse");
    a_srst_cause: assert property (SOFT_RST_PULSE |-> $past(rst_wr))
        else $error("stray reset pulse");
    a_srst_single: assert property (SOFT_RST_PULSE |=> !SOFT_RST_PULSE)
        else $error("reset pulse held");
endmodule : lmr_exec_monitor
bind lmr_exec lmr_exec_monitor u_mon (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SOFT_RST_PULSE(SOFT_RST_PULSE));
`default_nettype wire

// >>> lmr_exec_tb.sv
// self-checking bench for the execution unit, driven over apb
// assumes lmr_pkg and the bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h want %h", $time, a, e); end end
module lmr_exec_tb;
    import lmr_pkg::*;
    typedef struct {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] ex;} lmr_row_t;
    logic        SYS_CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic        PREADY, PSLVERR, SOFT_RST_PULSE, er;
    int          err_count = 0, checks_done = 0;
    lmr_row_t    rows [16];
    lmr_exec u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SOFT_RST_PULSE(SOFT_RST_PULSE));
    always #2 SYS_CLK = ~SYS_CLK;
    // one apb transfer, held until ready is sampled or 20 cycles pass
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge SYS_CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // watchdog against a hung handshake
    initial
    begin
        #40000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        rows = '{'{OFS_INSTR, 32'h305a, OFS_WORK, 32'h5a},
                 '{OFS_INSTR, 32'h003f, OFS_BANK, 32'h1f},
                 '{OFS_INSTR, 32'h31ff, OFS_PAGE, 32'h7f},
                 '{OFS_INSTR, 32'h0062, OFS_OPTION, 32'h5a},
                 '{OFS_FSP0, 32'hffff, OFS_FSP0, 32'hffff},
                 '{OFS_INSTR, 32'h0018, OFS_FSP0, 32'h0},
                 '{OFS_INSTR, 32'h0000, OFS_MEM_BASE, 32'h5a},
                 '{OFS_INSTR, 32'h001b, OFS_FSP0, 32'hffff},
                 '{OFS_INSTR, 32'h0019, OFS_FSP0, 32'hfffe},
                 '{OFS_INSTR, 32'h3f83, 12'h084, 32'h5a},
                 '{OFS_INSTR, 32'h3011, OFS_FLAGS, 32'h0},
                 '{OFS_INSTR, 32'h0080, 12'h0f8, 32'h11},
                 '{OFS_INSTR, 32'h3111, OFS_EXEC, 32'h2},
                 '{OFS_INSTR, 32'h0000, OFS_WORK, 32'h11},
                 '{OFS_INSTR, 32'h3f04, OFS_FLAGS, 32'h4},
                 '{OFS_INSTR, 32'h30a5, OFS_FLAGS, 32'h4}};
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        apb(1'b0, OFS_OPTION, 32'h0);
        `CK(rd, 32'hff)
        apb(1'b0, OFS_PWRCTL, 32'h0);
        `CK(rd, 32'h4)
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].wa, rows[i].wd);
            apb(1'b0, rows[i].ra, 32'h0);
            `CK(rd, rows[i].ex)
            $display("row %0d done", i);
        end
        // return pops the pushed address and enables interrupts
        apb(1'b1, OFS_STACK, 32'h1234);
        apb(1'b1, OFS_INSTR, 32'h9);
        apb(1'b0, OFS_PC, 32'h0);
        `CK(rd, 32'h1234)
        apb(1'b0, OFS_INTCTL, 32'h0);
        `CK(rd, 32'h80)
        apb(1'b0, OFS_FLAGS, 32'h0);
        `CK(rd, 32'h4)
        apb(1'b0, 12'h024, 32'h0);
        `CK(er, 1'b1)
        apb(1'b0, 12'h006, 32'h0);
        `CK(er, 1'b1)
        apb(1'b0, 12'h100, 32'h0);
        `CK(er, 1'b1)
        $display("return and unmapped done");
        // software reset clears the cause flag and the working register
        apb(1'b1, OFS_INSTR, 32'h1);
        @(posedge SYS_CLK);
        `CK(SOFT_RST_PULSE, 1'b1)
        apb(1'b0, OFS_PWRCTL, 32'h0);
        `CK(rd, 32'h0)
        apb(1'b0, OFS_WORK, 32'h0);
        `CK(rd, 32'h0)
        $display("software reset done");
        end_of_test();
    end
endmodule : lmr_exec_tb
`default_nettype wire
